// ===== hw/sdram_front_pkg.sv
// Shared constants and types for the SDRAM control-pin front end
package sdram_front_pkg;

  // Data bus geometry
  localparam int DATA_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int BYTES      = DATA_W / BYTE_W;
  localparam int FIFO_DEPTH = 16;

  // Command codes, formed as {row strobe, column strobe, write enable}
  localparam logic [2:0] CMD_MODE_SET  = 3'h0;
  localparam logic [2:0] CMD_REFRESH   = 3'h1;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_ACTIVATE  = 3'h3;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_READ      = 3'h5;
  localparam logic [2:0] CMD_BURST_END = 3'h6;
  localparam logic [2:0] CMD_NOP       = 3'h7;

  // Reset values
  localparam logic [2:0]        CMD_RESET  = CMD_NOP;
  localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;
  localparam logic [BYTES-1:0]  OEN_RESET  = 2'h3;
  localparam logic [BYTES-1:0]  BEN_RESET  = 2'h0;

  // Power state of the device while the clock is enabled or not
  typedef enum logic [3:0] {
    ST_RUN       = 4'h1,
    ST_POWERDOWN = 4'h2,
    ST_SUSPEND   = 4'h4,
    ST_SELFREF   = 4'h8
  } power_state_e;

  localparam power_state_e STATE_RESET = ST_RUN;

endpackage : sdram_front_pkg

// ===== hw/sdram_front_fifo.sv
// Synchronous FIFO with registered head data and valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module sdram_front_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output var  logic             inReady,
  output var  logic [WIDTH-1:0] outData,
  output var  logic             outValid,
  input  wire logic             outReady
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wrPtr_ff;
  logic [PW-1:0]    rdPtr_ff;
  logic [CW-1:0]    count_ff;
  logic [PW-1:0]    nxt_rdPtr;
  logic [CW-1:0]    nxt_count;
  logic             push;
  logic             pop;
  logic             inReady_ff;
  logic             outValid_ff;
  logic [WIDTH-1:0] outData_ff;

  assign push      = inValid && inReady_ff;
  assign pop       = outReady && outValid_ff;
  assign nxt_rdPtr = pop ? PW'(rdPtr_ff + 1'b1) : rdPtr_ff;
  assign nxt_count = count_ff + CW'(push) - CW'(pop);
  assign inReady   = inReady_ff;
  assign outValid  = outValid_ff;
  assign outData   = outData_ff;

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrPtr_ff    <= '0;
      rdPtr_ff    <= '0;
      count_ff    <= '0;
      inReady_ff  <= 1'b1;
      outValid_ff <= 1'b0;
      outData_ff  <= '0;
    end else begin
      wrPtr_ff    <= push ? PW'(wrPtr_ff + 1'b1) : wrPtr_ff;
      rdPtr_ff    <= nxt_rdPtr;
      count_ff    <= nxt_count;
      inReady_ff  <= nxt_count != FULL_COUNT;
      outValid_ff <= nxt_count != '0;
      // Bypass the word being written when it becomes the new head
      outData_ff  <= (push && nxt_rdPtr == wrPtr_ff) ? inData : mem[nxt_rdPtr];
    end
  end

endmodule : sdram_front_fifo
`default_nettype wire

// ===== hw/sdram_pin_front_end.sv
// SDRAM control-pin front end: clock enable, command capture, byte masks
//
// Contract
// - An edge counts only while clock enable is high; otherwise it is ignored, except that in a read burst its high masks still float bytes.
// - With clock enable low, device sits in power-down, suspend or self refresh.
// - Clock enable is taken asynchronously, through its own synchroniser.
// - All other inputs are captured on the rising clock edge.
// - A command is accepted on a valid edge only with chip select low.
// - Chip select high: commands ignored, internal state kept.
// - Command decoded from row strobe, column strobe, write enable together.
// - Low mask governs the low data byte, high mask the high byte.
// - On reads a low mask drives the byte; a high mask floats it.
// - On writes a low mask writes the byte; a high mask blocks it.
`timescale 1ns/10ps
`default_nettype none
module sdram_pin_front_end
  import sdram_front_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              clkEnablePin,
  input  wire logic              chipSelectN,
  input  wire logic              rowStrobeN,
  input  wire logic              colStrobeN,
  input  wire logic              writeEnableN,
  input  wire logic              lowByteMask,
  input  wire logic              highByteMask,
  input  wire logic [DATA_W-1:0] dataBus16In,
  output var  logic [DATA_W-1:0] dataBus16Out,
  output var  logic [BYTES-1:0]  dataBus16OeN,
  output var  logic              cmdValid,
  output var  logic [2:0]        cmdCode,
  output var  logic              wrValid,
  output var  logic [DATA_W-1:0] wrData,
  output var  logic [BYTES-1:0]  wrByteEn,
  input  wire logic [DATA_W-1:0] rdData,
  input  wire logic              rdValid,
  output var  logic              rdReady,
  output var  logic [3:0]        powerState
);

  ////////////////////////////////////////////////////////////////////////////
  // Command decode helper

  function automatic logic [2:0] decode_cmd(input logic ras, input logic cas,
                                            input logic we);
    decode_cmd = {ras, cas, we};
  endfunction : decode_cmd

  ////////////////////////////////////////////////////////////////////////////
  // Clock enable synchroniser

  logic ckeMeta_ff;
  logic ckeSync_ff;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      ckeMeta_ff <= 1'b0;
      ckeSync_ff <= 1'b0;
    end else begin
      ckeMeta_ff <= clkEnablePin;
      ckeSync_ff <= ckeMeta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin capture on the rising edge

  logic              csN_ff;
  logic              rasN_ff;
  logic              casN_ff;
  logic              weN_ff;
  logic [BYTES-1:0]  mask_ff;
  logic [DATA_W-1:0] dataIn_ff;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      csN_ff    <= 1'b1;
      rasN_ff   <= 1'b1;
      casN_ff   <= 1'b1;
      weN_ff    <= 1'b1;
      mask_ff   <= OEN_RESET;
      dataIn_ff <= DATA_RESET;
    end else begin
      csN_ff    <= chipSelectN;
      rasN_ff   <= rowStrobeN;
      casN_ff   <= colStrobeN;
      weN_ff    <= writeEnableN;
      mask_ff   <= {highByteMask, lowByteMask};
      dataIn_ff <= dataBus16In;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge qualification and command selection

  wire       edgeValid = ckeSync_ff;
  wire [2:0] pinCmd    = decode_cmd(rasN_ff, casN_ff, weN_ff);
  wire       cmdTaken  = edgeValid && !csN_ff;
  wire       isRead    = cmdTaken && pinCmd == CMD_READ;
  wire       isWrite   = cmdTaken && pinCmd == CMD_WRITE;
  wire       isRefresh = cmdTaken && pinCmd == CMD_REFRESH;
  wire       endsBurst = cmdTaken && pinCmd != CMD_NOP
                         && !isRead && !isWrite;

  ////////////////////////////////////////////////////////////////////////////
  // Burst direction tracking

  logic readActive_ff;
  logic writeActive_ff;
  logic nxt_readActive;
  logic nxt_writeActive;

  assign nxt_readActive  = isRead ? 1'b1 :
                           (isWrite || endsBurst) ? 1'b0 : readActive_ff;
  assign nxt_writeActive = isWrite ? 1'b1 :
                           (isRead || endsBurst) ? 1'b0 : writeActive_ff;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      readActive_ff  <= 1'b0;
      writeActive_ff <= 1'b0;
    end else begin
      readActive_ff  <= nxt_readActive;
      writeActive_ff <= nxt_writeActive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state

  power_state_e state_ff;
  power_state_e nxt_state;
  logic         refreshTaken_ff;
  wire          burstBusy = readActive_ff || writeActive_ff;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (!edgeValid) begin
          // A refresh taken on the last valid edge enters self refresh
          nxt_state = refreshTaken_ff ? ST_SELFREF :
                      burstBusy ? ST_SUSPEND : ST_POWERDOWN;
        end
      end
      ST_POWERDOWN, ST_SUSPEND: begin
        if (edgeValid) begin
          nxt_state = ST_RUN;
        end
      end
      ST_SELFREF: begin
        if (edgeValid) begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_RUN;
    endcase
  end

  // Only the second synchroniser stage is read, so self refresh is
  // recognised one edge after the refresh, when that edge is invalid
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_ff        <= STATE_RESET;
      refreshTaken_ff <= 1'b0;
    end else begin
      state_ff        <= nxt_state;
      refreshTaken_ff <= isRefresh;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command report

  logic       cmdValid_ff;
  logic [2:0] cmdCode_ff;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cmdValid_ff <= 1'b0;
      cmdCode_ff  <= CMD_RESET;
    end else begin
      cmdValid_ff <= cmdTaken && pinCmd != CMD_NOP;
      cmdCode_ff  <= cmdTaken ? pinCmd : cmdCode_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write data path

  logic              wrValid_ff;
  logic [DATA_W-1:0] wrData_ff;
  logic [BYTES-1:0]  wrByteEn_ff;
  wire               wrBeat = edgeValid && (isWrite || (writeActive_ff
                              && !(cmdTaken && pinCmd != CMD_NOP)));

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      wrValid_ff  <= 1'b0;
      wrData_ff   <= DATA_RESET;
      wrByteEn_ff <= BEN_RESET;
    end else begin
      wrValid_ff  <= wrBeat && mask_ff != OEN_RESET;
      wrData_ff   <= wrBeat ? dataIn_ff : wrData_ff;
      wrByteEn_ff <= wrBeat ? ~mask_ff : BEN_RESET;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data path through the FIFO

  logic [DATA_W-1:0] fifoData;
  logic              fifoValid;
  logic              fifoReady;
  logic [DATA_W-1:0] dataOut_ff;
  logic [BYTES-1:0]  dataOeN_ff;
  wire               rdBeat = edgeValid && readActive_ff && fifoValid;

  sdram_front_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_read_fifo (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .inData   (rdData),
    .inValid  (rdValid),
    .inReady  (fifoReady),
    .outData  (fifoData),
    .outValid (fifoValid),
    .outReady (rdBeat)
  );

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      dataOut_ff <= DATA_RESET;
      dataOeN_ff <= OEN_RESET;
    end else begin
      dataOut_ff <= rdBeat ? fifoData : dataOut_ff;
      // Masked bytes float; a suspended edge holds the driven word
      if (rdBeat) begin
        dataOeN_ff <= mask_ff;
      end else if (!(edgeValid && readActive_ff)) begin
        dataOeN_ff <= readActive_ff ? dataOeN_ff | mask_ff
                                    : OEN_RESET;
      end else begin
        dataOeN_ff <= OEN_RESET;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign dataBus16Out = dataOut_ff;
  assign dataBus16OeN = dataOeN_ff;
  assign cmdValid     = cmdValid_ff;
  assign cmdCode      = cmdCode_ff;
  assign wrValid      = wrValid_ff;
  assign wrData       = wrData_ff;
  assign wrByteEn     = wrByteEn_ff;
  assign rdReady      = fifoReady;
  assign powerState   = state_ff;

endmodule : sdram_pin_front_end
`default_nettype wire

// ===== dv/sdram_front_props.sv
// Port-level assertions for the SDRAM control-pin front end
`timescale 1ns/10ps
`default_nettype none
module sdram_front_props
  import sdram_front_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              reset_n,
  input wire logic              clkEnablePin,
  input wire logic              chipSelectN,
  input wire logic              rowStrobeN,
  input wire logic              colStrobeN,
  input wire logic              writeEnableN,
  input wire logic              lowByteMask,
  input wire logic              highByteMask,
  input wire logic [DATA_W-1:0] dataBus16In,
  input wire logic              cmdValid,
  input wire logic [2:0]        cmdCode,
  input wire logic              wrValid,
  input wire logic [DATA_W-1:0] wrData,
  input wire logic [BYTES-1:0]  wrByteEn,
  input wire logic [3:0]        powerState
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  // Consecutive edges with clock enable low, saturating
  logic [2:0] lowCnt_ff;
  always_ff @(posedge core_clk) begin
    if (!reset_n || clkEnablePin) lowCnt_ff <= 3'h0;
    else if (lowCnt_ff != 3'h7) lowCnt_ff <= lowCnt_ff + 3'h1;
  end
  property p_csIgnored;
    $past(chipSelectN, 2) |-> !cmdValid;
  endproperty
  a_csIgnored: assert property (p_csIgnored)
    else $error("command accepted with chip select high");
  property p_nopSilent;
    $past({rowStrobeN, colStrobeN, writeEnableN}, 2) == CMD_NOP |-> !cmdValid;
  endproperty
  a_nopSilent: assert property (p_nopSilent)
    else $error("no-operation produced a command pulse");
  property p_cmdCode;
    cmdValid |-> cmdCode == $past({rowStrobeN, colStrobeN, writeEnableN}, 2);
  endproperty
  a_cmdCode: assert property (p_cmdCode)
    else $error("command code differs from strobe pins");
  property p_edgeGated;
    lowCnt_ff >= 3'h3 |-> !cmdValid && !wrValid;
  endproperty
  a_edgeGated: assert property (p_edgeGated)
    else $error("activity on a disabled clock edge");
  property p_lowPower;
    lowCnt_ff >= 3'h5
      |-> powerState inside {ST_POWERDOWN, ST_SUSPEND, ST_SELFREF};
  endproperty
  a_lowPower: assert property (p_lowPower)
    else $error("running while clock enable held low");
  property p_wrBytes;
    wrValid |-> wrByteEn == ~$past({highByteMask, lowByteMask}, 2);
  endproperty
  a_wrBytes: assert property (p_wrBytes)
    else $error("write byte enables differ from masks");
  property p_wrData;
    wrValid |-> wrData == $past(dataBus16In, 2);
  endproperty
  a_wrData: assert property (p_wrData)
    else $error("write data differs from captured bus");
  property p_bothMasked;
    $past(lowByteMask && highByteMask, 2) |-> !wrValid;
  endproperty
  a_bothMasked: assert property (p_bothMasked)
    else $error("write beat with both bytes masked");
endmodule : sdram_front_props
bind sdram_pin_front_end sdram_front_props u_props (
  .core_clk(core_clk), .reset_n(reset_n), .clkEnablePin(clkEnablePin),
  .chipSelectN(chipSelectN), .rowStrobeN(rowStrobeN), .colStrobeN(colStrobeN),
  .writeEnableN(writeEnableN), .lowByteMask(lowByteMask),
  .highByteMask(highByteMask), .dataBus16In(dataBus16In), .cmdValid(cmdValid),
  .cmdCode(cmdCode), .wrValid(wrValid), .wrData(wrData), .wrByteEn(wrByteEn),
  .powerState(powerState));
`default_nettype wire

// ===== dv/sdram_ctrl_model.sv
// Behavioural memory controller driving pins and read-path words
`timescale 1ns/10ps
`default_nettype none
module sdram_ctrl_model
  import sdram_front_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rdReady,
  output var  logic              clkEnablePin,
  output var  logic              chipSelectN,
  output var  logic [2:0]        cmdPins,
  output var  logic [1:0]        maskPins,
  output var  logic [DATA_W-1:0] dataPins,
  output var  logic [DATA_W-1:0] rdData,
  output var  logic              rdValid
);
  initial begin
    clkEnablePin = 1'b1;
    chipSelectN = 1'b1;
    cmdPins = CMD_NOP;
    maskPins = 2'h3;
    dataPins = 16'h0000;
    rdData = 16'h0000;
    rdValid = 1'b0;
  end
  // Pins change at the falling edge so they are stable at capture
  task automatic drive(input logic cs, input logic [2:0] c,
                       input logic [1:0] m, input logic [15:0] d);
    @(negedge core_clk);
    chipSelectN = cs;
    cmdPins = c;
    maskPins = m;
    dataPins = d;
  endtask : drive
  // Deselect; a released bus shows the inverse of its last value
  task automatic idle();
    drive(1'b1, CMD_NOP, 2'h3, ~dataPins);
  endtask : idle
  // Offer a word only while ready, which is stable until the next edge
  task automatic fill(output int n);
    n = 0;
    @(negedge core_clk);
    while (rdReady && n < 20) begin
      rdData = 16'ha000 + n[15:0];
      rdValid = 1'b1;
      n++;
      @(negedge core_clk);
    end
    rdValid = 1'b0;
    rdData = ~rdData;
  endtask : fill
endmodule : sdram_ctrl_model
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking testbench for the SDRAM control-pin front end
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import sdram_front_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  int   error_cnt = 0;
  int   tests_run = 0;
  int   cycles = 0;
  logic cke, csN, rdV, rdRdy, cmdValid, wrValid;
  logic [2:0]  cmdPins, cmdCode;
  logic [1:0]  maskPins, oeN, wrByteEn;
  logic [15:0] dIn, dOut, rdD, wrData;
  logic [3:0]  powerState;
  always #5 core_clk = ~core_clk;
  sdram_ctrl_model u_ctrl (.core_clk(core_clk), .rdReady(rdRdy),
    .clkEnablePin(cke), .chipSelectN(csN), .cmdPins(cmdPins),
    .maskPins(maskPins), .dataPins(dIn), .rdData(rdD), .rdValid(rdV));
  sdram_pin_front_end DUT (.core_clk(core_clk), .reset_n(reset_n),
    .clkEnablePin(cke), .chipSelectN(csN), .rowStrobeN(cmdPins[2]),
    .colStrobeN(cmdPins[1]), .writeEnableN(cmdPins[0]),
    .lowByteMask(maskPins[0]), .highByteMask(maskPins[1]),
    .dataBus16In(dIn), .dataBus16Out(dOut), .dataBus16OeN(oeN),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .wrValid(wrValid),
    .wrData(wrData), .wrByteEn(wrByteEn), .rdData(rdD), .rdValid(rdV),
    .rdReady(rdRdy), .powerState(powerState));
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // One command, then deselect; the pulse shows one edge after capture
  task automatic send(input logic cs, input logic [2:0] c,
                      input logic [1:0] m, input logic [15:0] d,
                      input logic v);
    u_ctrl.drive(cs, c, m, d);
    u_ctrl.idle();
    @(negedge core_clk);
    check("cmdValid", cmdValid, v);
  endtask : send
  //////////////////////////////////////////////////////////////////////////
  task automatic t_commands();
    for (int c = 0; c < 7; c++) begin
      send(1'b0, c[2:0], 2'h3, 16'h0000, 1'b1);
      check("cmdCode", cmdCode, c[2:0]);
      if (c == 4) check("wrValid", wrValid, 1'b0);
    end
    send(1'b0, CMD_NOP, 2'h3, 16'h0000, 1'b0);
    send(1'b1, CMD_ACTIVATE, 2'h3, 16'h0000, 1'b0);
    check("cmdCode", cmdCode, CMD_NOP);
  endtask : t_commands
  task automatic t_write();
    logic [1:0] en;
    for (int m = 0; m < 3; m++) begin
      en = ~m[1:0];
      send(1'b0, CMD_WRITE, m[1:0], 16'h5a00 + m[15:0], 1'b1);
      check("wrValid", wrValid, 1'b1);
      check("wrData", wrData, 16'h5a00 + m[15:0]);
      check("wrByteEn", wrByteEn, en);
    end
    send(1'b0, CMD_PRECHARGE, 2'h3, 16'h0000, 1'b1);
  endtask : t_write
  task automatic t_power();
    @(negedge core_clk);
    u_ctrl.clkEnablePin = 1'b0;
    repeat (5) @(negedge core_clk);
    check("powerState", powerState, ST_POWERDOWN);
    send(1'b0, CMD_ACTIVATE, 2'h3, 16'h0000, 1'b0);
    u_ctrl.clkEnablePin = 1'b1;
    repeat (4) @(negedge core_clk);
    check("powerState", powerState, ST_RUN);
  endtask : t_power
  task automatic t_suspend();
    send(1'b0, CMD_WRITE, 2'h0, 16'h1111, 1'b1);
    // Deselected burst beat with both bytes open, then clock enable drops
    u_ctrl.drive(1'b1, CMD_NOP, 2'h0, 16'h2222);
    u_ctrl.clkEnablePin = 1'b0;
    repeat (2) @(negedge core_clk);
    check("wrValid", wrValid, 1'b1);
    check("wrData", wrData, 16'h2222);
    @(negedge core_clk);
    check("wrValid", wrValid, 1'b0);
    check("powerState", powerState, ST_SUSPEND);
    u_ctrl.clkEnablePin = 1'b1;
    send(1'b0, CMD_PRECHARGE, 2'h3, 16'h0000, 1'b1);
    check("powerState", powerState, ST_RUN);
  endtask : t_suspend
  task automatic t_selfref();
    // Refresh presented on the edge at which clock enable falls
    u_ctrl.drive(1'b0, CMD_REFRESH, 2'h3, 16'h0000);
    u_ctrl.clkEnablePin = 1'b0;
    u_ctrl.idle();
    repeat (3) @(negedge core_clk);
    check("powerState", powerState, ST_SELFREF);
    check("cmdCode", cmdCode, CMD_REFRESH);
    u_ctrl.clkEnablePin = 1'b1;
    repeat (4) @(negedge core_clk);
    check("powerState", powerState, ST_RUN);
  endtask : t_selfref
  task automatic t_read();
    int n;
    int i;
    u_ctrl.fill(n);
    check("fifo words", n[15:0], 16'h0010);
    check("rdReady", rdRdy, 1'b0);
    u_ctrl.drive(1'b0, CMD_READ, 2'h2, 16'h0000);
    u_ctrl.drive(1'b1, CMD_NOP, 2'h2, 16'hffff);
    i = 0;
    repeat (40) begin
      @(negedge core_clk);
      if (oeN !== 2'h3) begin
        check("dataBus16Out", dOut, 16'ha000 + i[15:0]);
        check("dataBus16OeN", oeN, 2'h2);
        i++;
      end
    end
    check("read beats", i[15:0], 16'h0010);
    check("rdReady", rdRdy, 1'b1);
  endtask : t_read
  //////////////////////////////////////////////////////////////////////////
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    repeat (16) @(negedge core_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge core_clk);
    check("dataBus16OeN", oeN, OEN_RESET);
    check("powerState", powerState, ST_RUN);
    check("cmdCode", cmdCode, CMD_RESET);
    t_commands();
    t_write();
    t_power();
    t_suspend();
    t_selfref();
    t_read();
    summarize();
  end
endmodule : testbench
`default_nettype wire
